// ===== l2ctl_pkg.sv
// Purpose: Constants and types shared by the L2 mode and coherence control.
// Assumes: Classic Wishbone slave with 32-bit data and byte addresses.
// Notes: 128-byte lines; 4 ways; sizes in KB.
// Contract
// R1: Global reset selects all-RAM, no cache.
// R2: Local reset keeps size, invalidates, stalls requestors.
// R3: First-level caches follow the same resets.
// R4: Cache limit is min(power-of-two fit, 256K).
// R5: Codes 0..4 give 0K..256K; 5..7 mean 256K.
// R6: Software empties RAM range before growing cache.
// R7: Config read stalls until size change completes.
// R8: Size write flushes enabled cache, then switches.
// R9: Size change leaves first-level caches untouched.
// R10: Frozen: hits normal, misses bypass, no allocation.
// R11: Frozen lines leave only by coherence commands.
// R12: Freeze touches only the cache portion.
// R13: Frozen misses are single accesses, no LRU updates.
// R14: Global writeback: data cache and L2, lines valid.
// R15: Global writeback-invalidate flushes and invalidates all three.
// R16: Global invalidate drops everything in all three.
// R17: Command bit set by software, cleared on completion.
// R18: Coherence works frozen; freeze state kept.
// R19: Software writes base, then word count.
// R20: Block commands act like globals within range.
// R21: One operation at a time; register writes stall.
// R22: Nonzero count starts; reads nonzero until done.
package l2ctl_pkg;
   localparam int ADR_W = 8;
   // ------------------------------------------------------------
   // Register offsets
   // ------------------------------------------------------------
   localparam logic [7:0] CFG_OFF = 8'h00;
   localparam logic [7:0] GCMD_OFF = 8'h04;
   localparam logic [7:0] BLK_OFF = 8'h10;
   localparam logic [7:0] STAT_OFF = 8'h28;
   localparam int GCMD_STEP = 4;
   localparam int BLK_STEP = 8;
   localparam int BLK_CNT_OFS = 4;
   // ------------------------------------------------------------
   // Fields and reset values
   // ------------------------------------------------------------
   localparam int CFG_SIZE_LSB = 0;
   localparam int CFG_FREEZE_BIT = 3;
   localparam int CMD_BIT = 0;
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_SIZE_LSB = 4;
   localparam logic [2:0] SIZE_NONE = 3'h0;
   localparam logic [2:0] SIZE_256K = 3'h4;
   localparam logic [2:0] SIZE_RST = SIZE_NONE;
   localparam logic FREEZE_RST = 1'b0;
   // ------------------------------------------------------------
   // Geometry
   // ------------------------------------------------------------
   localparam int LINE_OFS = 7;
   localparam int WORD_SHIFT = 2;
   localparam int LINE_W = 32 - LINE_OFS;
   localparam int SET_W = 9;
   localparam logic [SET_W:0] SETS_32K = 10'h040;
   localparam int MIN_CACHE_KB = 32;
   localparam int MAX_CACHE_KB = 256;
   typedef enum {S_IDLE, S_INIT, S_WALK} state_type;
   typedef enum {K_INIT, K_RESIZE, K_GWB, K_GWBI, K_GINV,
                 K_BWB, K_BWBI, K_BINV} kind_type;
endpackage

// ===== size_decode.sv
// Purpose: Effective cache size and last set index from the size select.
// Assumes: Port 0 memory size given in KB.
// Notes: Purely combinational.
`timescale 1ns/10ps
module size_decode
   import l2ctl_pkg::*;
#(
   parameter int PORT0_KB = 256
)(
   input wire logic [2:0] sel_i,
   output logic [2:0] eff_o,
   output logic [SET_W-1:0] last_set_o,
   output logic [SET_W-1:0] max_last_o
);
   // Largest usable code for this memory
   localparam int FIT_KB = (PORT0_KB < MAX_CACHE_KB) ? PORT0_KB : MAX_CACHE_KB;
   localparam logic [2:0] MAX_CODE =
      (FIT_KB >= 256) ? 3'h4 : (FIT_KB >= 128) ? 3'h3 :
      (FIT_KB >= 64) ? 3'h2 : (FIT_KB >= 32) ? 3'h1 : 3'h0;
   if (PORT0_KB < MIN_CACHE_KB) begin : g_bad
      $error("size_decode: port 0 memory too small for any cache");
   end
   wire [2:0] clamp = (sel_i > SIZE_256K) ? SIZE_256K : sel_i; // [R5]
   wire [SET_W:0] sets = SETS_32K << (eff_o - 3'h1);
   wire [SET_W:0] max_sets = SETS_32K << (MAX_CODE - 3'h1);
   assign eff_o = (clamp > MAX_CODE) ? MAX_CODE : clamp; // [R4]
   assign last_set_o = (eff_o == SIZE_NONE) ? '0 : SET_W'(sets - 10'h001);
   assign max_last_o = (MAX_CODE == SIZE_NONE) ? '0 : SET_W'(max_sets - 10'h001);
endmodule

// ===== line_walker.sv
// Purpose: Steps a line index from a first to a last value.
// Assumes: Start and step never coincide.
// Notes: Index register drives the operation line directly.
`timescale 1ns/10ps
module line_walker #(
   parameter int W = 25
)(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic start_i,
   input wire logic step_i,
   input wire logic [W-1:0] first_i,
   input wire logic [W-1:0] last_i,
   output logic [W-1:0] cur_o,
   output logic at_last_o
);
   assign at_last_o = (cur_o == last_i);
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cur_o <= '0;
      end else if (ce_i) begin
         if (start_i) begin
            cur_o <= first_i;
         end else if (step_i && !at_last_o) begin
            cur_o <= cur_o + W'(1);
         end
      end
   end
endmodule

// ===== l2_mode_coherence_ctrl.sv
// Purpose: L2 size, freeze and coherence command control.
// Assumes: Cache arrays and first-level caches obey the op stream.
// Notes: One line operation per op_valid_o/op_ready_i handshake.
`timescale 1ns/10ps
module l2_mode_coherence_ctrl
   import l2ctl_pkg::*;
#(
   parameter int PORT0_KB = 256,
   parameter int WC_W = 16,
   parameter bit L1_EN = 1'b1
)(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic lrst_i,
   input wire logic ce_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [ADR_W-1:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   output logic op_valid_o,
   input wire logic op_ready_i,
   output logic op_global_o,
   output logic [LINE_W-1:0] op_line_o,
   output logic op_l2_wb_o,
   output logic op_l2_inv_o,
   output logic op_l1d_wb_o,
   output logic op_l1d_inv_o,
   output logic op_l1p_inv_o,
   output logic req_stall_o,
   output logic [2:0] size_eff_o,
   output logic [SET_W-1:0] last_set_o,
   output logic freeze_o,
   output logic alloc_en_o,
   output logic lru_upd_en_o,
   output logic miss_bypass_o
);
   if (WC_W < 1 || WC_W > 30) begin : g_bad
      $error("l2_mode_coherence_ctrl: WC_W must be 1..30");
   end

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   localparam kind_type GKIND [3] = '{K_GWB, K_GWBI, K_GINV};
   localparam kind_type BKIND [3] = '{K_BWB, K_BWBI, K_BINV};
   state_type state;
   kind_type kind;
   kind_type l_kind;
   logic ack;
   logic freeze;
   logic [2:0] size_sel;
   logic [2:0] pending;
   logic [2:0] cmd;
   logic [31:0] base [3];
   logic [WC_W-1:0] cnt [3];
   logic [WC_W-1:0] cnt_new [3];
   logic [31:0] blk_end [3];
   logic [LINE_W-1:0] op_last;
   logic [31:0] rdata;
   logic [31:0] rmux;
   logic launch;
   logic [LINE_W-1:0] l_first;
   logic [LINE_W-1:0] l_last;
   logic [SET_W-1:0] max_last;
   logic [LINE_W-1:0] cur;
   logic at_last;
   logic [2:0] gcmd_hit;
   logic [2:0] base_hit;
   logic [2:0] cnt_hit;

   // ------------------------------------------------------------
   // Bus decode
   // ------------------------------------------------------------
   wire wb_req = cyc_i && stb_i;
   wire busy = (state != S_IDLE);
   wire hold = busy && (we_i || adr_i == CFG_OFF); // [R7] [R21]
   wire take = wb_req && !ack && !hold;
   wire wr = take && we_i;
   wire [31:0] wmask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
   wire cfg_wr = wr && adr_i == CFG_OFF && sel_i[0];
   wire size_new = cfg_wr && dat_i[CFG_SIZE_LSB +: 3] != size_sel;
   wire cache_on = (size_eff_o != SIZE_NONE);
   wire step = op_valid_o && op_ready_i;
   wire done = step && at_last;
   wire walker_rst = rst_i || lrst_i;

   // ------------------------------------------------------------
   // Size decode and line walker
   // ------------------------------------------------------------
   size_decode #(
      .PORT0_KB(PORT0_KB)
   ) u_size (
      .sel_i(size_sel),
      .eff_o(size_eff_o),
      .last_set_o(last_set_o),
      .max_last_o(max_last)
   );

   line_walker #(
      .W(LINE_W)
   ) u_walk (
      .clk_i(clk_i),
      .rst_i(walker_rst),
      .ce_i(ce_i),
      .start_i(launch),
      .step_i(step),
      .first_i(l_first),
      .last_i(op_last),
      .cur_o(cur),
      .at_last_o(at_last)
   );

   // ------------------------------------------------------------
   // Per-entry registers
   // ------------------------------------------------------------
   for (genvar i = 0; i < 3; i++) begin : g_ent
      localparam logic [7:0] GOFF = 8'(GCMD_OFF + GCMD_STEP * i);
      localparam logic [7:0] BOFF = 8'(BLK_OFF + BLK_STEP * i);
      localparam logic [7:0] COFF = 8'(BLK_OFF + BLK_STEP * i + BLK_CNT_OFS);
      wire [31:0] cnt_ext = {{(32 - WC_W){1'b0}}, cnt[i]};
      wire [31:0] cnt_mrg = (cnt_ext & ~wmask) | (dat_i & wmask);
      wire [31:0] base_al = {base[i][31:WORD_SHIFT], 2'b00};
      assign gcmd_hit[i] = wr && adr_i == GOFF && sel_i[0];
      assign base_hit[i] = wr && adr_i == BOFF;
      assign cnt_hit[i] = wr && adr_i == COFF;
      assign cnt_new[i] = cnt_mrg[WC_W-1:0];
      // Address of the last word in the range, lines that overlap it
      assign blk_end[i] = base_al + {{(30 - WC_W){1'b0}}, cnt_new[i], 2'b00}
                          - 32'h0000_0004; // [R22]
      always_ff @(posedge clk_i) begin
         if (walker_rst) begin
            cmd[i] <= 1'b0;
            cnt[i] <= '0;
            base[i] <= 32'h0000_0000;
         end else if (ce_i) begin
            if (gcmd_hit[i] && dat_i[CMD_BIT]) begin
               cmd[i] <= 1'b1; // [R17]
            end else if (done && kind == GKIND[i]) begin
               cmd[i] <= 1'b0; // [R17]
            end
            if (base_hit[i]) begin
               base[i] <= (base[i] & ~wmask) | (dat_i & wmask); // [R19]
            end
            if (cnt_hit[i]) begin
               cnt[i] <= cnt_new[i];
            end else if (done && kind == BKIND[i]) begin
               cnt[i] <= '0; // [R22]
            end
         end
      end
   end

   // ------------------------------------------------------------
   // Operation launch
   // ------------------------------------------------------------
   always_comb begin
      launch = 1'b0;
      l_kind = K_RESIZE;
      l_first = '0;
      l_last = LINE_W'(last_set_o);
      if (size_new && cache_on) begin
         launch = 1'b1; // [R8]
      end
      for (int i = 0; i < 3; i++) begin
         if (gcmd_hit[i] && dat_i[CMD_BIT]) begin
            launch = 1'b1;
            l_kind = GKIND[i];
         end
         if (cnt_hit[i] && cnt_new[i] != '0) begin
            launch = 1'b1; // [R22]
            l_kind = BKIND[i];
            l_first = base[i][31:LINE_OFS];
            l_last = blk_end[i][31:LINE_OFS];
         end
      end
   end

   // ------------------------------------------------------------
   // Sequencer
   // ------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state <= S_INIT; // [R1] [R3]
         kind <= K_INIT;
         op_last <= LINE_W'(max_last);
         size_sel <= SIZE_RST; // [R1]
         pending <= SIZE_RST;
         freeze <= FREEZE_RST;
      end else if (lrst_i) begin
         state <= S_INIT; // [R2]
         kind <= K_INIT;
         op_last <= LINE_W'(max_last);
      end else if (ce_i) begin
         if (launch) begin
            state <= S_WALK; // [R21]
            kind <= l_kind;
            op_last <= l_last;
         end else if (done) begin
            state <= S_IDLE;
         end
         if (done && kind == K_RESIZE) begin
            size_sel <= pending; // [R8]
         end
         if (cfg_wr) begin
            freeze <= dat_i[CFG_FREEZE_BIT]; // [R18]
            pending <= dat_i[CFG_SIZE_LSB +: 3];
            if (!cache_on) begin
               size_sel <= dat_i[CFG_SIZE_LSB +: 3];
            end
         end
      end
   end

   // ------------------------------------------------------------
   // Operation stream
   // ------------------------------------------------------------
   wire k_block = (kind == K_BWB || kind == K_BWBI || kind == K_BINV);
   wire k_wb = (kind == K_GWB || kind == K_BWB); // [R14] [R20]
   wire k_wbi = (kind == K_GWBI || kind == K_BWBI); // [R15] [R20]
   wire k_inv = (kind == K_GINV || kind == K_BINV); // [R16] [R20]
   assign op_valid_o = busy && ce_i;
   assign op_line_o = cur;
   assign op_global_o = !k_block;
   assign op_l2_wb_o = k_wb || k_wbi || kind == K_RESIZE; // [R8]
   assign op_l2_inv_o = k_wbi || k_inv || kind == K_RESIZE || kind == K_INIT; // [R2]
   assign op_l1d_wb_o = L1_EN && (k_wb || k_wbi); // [R9]
   assign op_l1d_inv_o = L1_EN && (k_wbi || k_inv || kind == K_INIT); // [R3]
   assign op_l1p_inv_o = L1_EN && (k_wbi || k_inv || kind == K_INIT); // [R3]
   assign req_stall_o = (state == S_INIT); // [R2]

   // ------------------------------------------------------------
   // Freeze controls
   // ------------------------------------------------------------
   assign freeze_o = freeze; // [R12]
   assign alloc_en_o = cache_on && !freeze; // [R10] [R11]
   assign lru_upd_en_o = cache_on && !freeze; // [R13]
   assign miss_bypass_o = cache_on && freeze; // [R10] [R13]

   // ------------------------------------------------------------
   // Read data and acknowledge
   // ------------------------------------------------------------
   always_comb begin
      rmux = 32'h0000_0000;
      if (adr_i == CFG_OFF) begin
         rmux[CFG_SIZE_LSB +: 3] = size_sel;
         rmux[CFG_FREEZE_BIT] = freeze;
      end
      if (adr_i == STAT_OFF) begin
         rmux[STAT_BUSY_BIT] = busy;
         rmux[STAT_SIZE_LSB +: 3] = size_eff_o;
      end
      for (int i = 0; i < 3; i++) begin
         if (adr_i == 8'(GCMD_OFF + GCMD_STEP * i)) begin
            rmux[CMD_BIT] = cmd[i];
         end
         if (adr_i == 8'(BLK_OFF + BLK_STEP * i)) begin
            rmux = {base[i][31:WORD_SHIFT], 2'b00};
         end
         if (adr_i == 8'(BLK_OFF + BLK_STEP * i + BLK_CNT_OFS)) begin
            rmux = {{(32 - WC_W){1'b0}}, cnt[i]}; // [R22]
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack <= 1'b0;
         rdata <= 32'h0000_0000;
      end else if (ce_i) begin
         ack <= take;
         if (take && !we_i) begin
            rdata <= rmux;
         end
      end
   end
   assign ack_o = ack;
   assign dat_o = rdata;

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence cfg_read_busy;
      wb_req && !we_i && adr_i == CFG_OFF && busy && !ack;
   endsequence
   sequence op_finish(kind_type k);
      done && ce_i && kind == k && !lrst_i;
   endsequence

   AST_RESET_ALL_RAM: assert property ($fell(rst_i) |-> size_sel == SIZE_NONE) // [R1]
      else $error("global reset left cache enabled");
   AST_LOCAL_RESET: assert property (lrst_i |=> req_stall_o && size_sel == $past(size_sel)) // [R2]
      else $error("local reset did not stall or lost size");
   AST_L1_FOLLOWS: assert property (req_stall_o |-> op_l1p_inv_o == L1_EN && op_l2_inv_o) // [R3]
      else $error("reset invalidation skipped a first-level cache");
   AST_SIZE_CLAMP: assert property (size_sel > SIZE_256K && PORT0_KB >= MAX_CACHE_KB // [R5]
                                    |-> size_eff_o == SIZE_256K)
      else $error("size code not mapped");
   AST_MAX_SIZE: assert property (size_eff_o <= SIZE_256K) // [R4]
      else $error("effective size beyond limit");
   AST_CFG_STALL: assert property (cfg_read_busy |=> !ack_o) // [R7]
      else $error("config read answered during operation");
   AST_RESIZE_FLUSH: assert property (busy && kind == K_RESIZE |-> // [R8] [R9]
                                      op_l2_wb_o && op_l2_inv_o && !op_l1d_inv_o
                                      && !op_l1p_inv_o && !op_l1d_wb_o)
      else $error("resize flush touched wrong caches");
   AST_RESIZE_APPLY: assert property (op_finish(K_RESIZE) |=> size_sel == $past(pending)) // [R8]
      else $error("size not applied after flush");
   AST_FREEZE_NO_ALLOC: assert property (freeze_o |-> !alloc_en_o && !lru_upd_en_o // [R10] [R13]
                                         && miss_bypass_o == cache_on)
      else $error("frozen cache may allocate");
   AST_CMD_CLEAR: assert property (op_finish(K_GWBI) |=> !cmd[1] && state == S_IDLE) // [R17]
      else $error("global command bit not cleared");
   AST_FREEZE_KEPT: assert property (done && ce_i && !lrst_i |=> freeze == $past(freeze)) // [R18]
      else $error("operation changed freeze state");
   AST_ONE_OP: assert property (busy && wb_req && we_i && ce_i |=> !ack_o) // [R21]
      else $error("register write accepted during operation");
   AST_COUNT_BUSY: assert property (cnt_hit[0] && cnt_new[0] != '0 && ce_i && !lrst_i // [R22]
                                    |=> busy && cnt[0] != '0 && kind == K_BWB)
      else $error("block count did not start operation");

   sequence op_launch;
      launch && ce_i && !lrst_i;
   endsequence

   AST_FIRST_LINE: assert property (op_launch |=> busy && op_line_o == $past(l_first)) // [R22]
      else $error("walk did not start at first line");
   AST_ZERO_COUNT: assert property (!busy && cnt_hit[0] && cnt_new[0] == '0 && !lrst_i // [R22]
                                    |=> !busy)
      else $error("zero count started an operation");

   AST_LOCAL_CLEARS: assert property (lrst_i |=> cmd == 3'h0 && state == S_INIT) // [R2]
      else $error("local reset kept a command");
   AST_GLOBAL_SPAN: assert property (busy && op_global_o && kind != K_INIT // [R14] [R15] [R16]
                                     |-> op_line_o <= LINE_W'(last_set_o))
      else $error("global walk beyond cache sets");
endmodule

// ===== l2_op_sink.sv
// Purpose: Far-side model of the cache arrays and first-level caches.
// Assumes: One line operation is accepted per op_valid/op_ready handshake.
// Notes: Slow mode accepts on every other cycle only; records what it saw.
`timescale 1ns/10ps
module l2_op_sink
   import l2ctl_pkg::*;
(
   input wire logic clk_i,
   input wire logic clr_i,
   input wire logic slow_i,
   input wire logic op_valid_i,
   input wire logic [LINE_W-1:0] op_line_i,
   input wire logic [4:0] flags_i,
   output logic op_ready_o,
   output logic [15:0] hs_count_o,
   output logic [LINE_W-1:0] first_line_o,
   output logic [LINE_W-1:0] last_line_o,
   output logic [4:0] flags_seen_o
);
   // ---------------------------------------------
   // Acceptance and bookkeeping
   // ---------------------------------------------
   logic toggle;
   wire logic take = op_valid_i && op_ready_o;

   assign op_ready_o = !slow_i || toggle;

   always_ff @(posedge clk_i) begin
      if (clr_i) begin
         toggle <= 1'b0;
         hs_count_o <= 16'h0;
         first_line_o <= '0;
         last_line_o <= '0;
         flags_seen_o <= 5'h0;
      end else begin
         toggle <= ~toggle;
         if (take) begin
            if (hs_count_o == 16'h0) begin
               first_line_o <= op_line_i;
            end
            last_line_o <= op_line_i;
            hs_count_o <= hs_count_o + 16'h1;
            // Union of actions over the whole walk
            flags_seen_o <= flags_seen_o | flags_i;
         end
      end
   end
endmodule

// ===== l2_mode_coherence_ctrl_tb.sv
// Purpose: Self-checking bench for the L2 mode and coherence control.
// Assumes: Design defaults: 256K port 0, first-level support on.
// Notes: Action flags are packed as l2_wb, l2_inv, l1d_wb, l1d_inv, l1p_inv.
`timescale 1ns/10ps
module l2_mode_coherence_ctrl_tb
   import l2ctl_pkg::*;
;
   // ---------------------------------------------
   // Signals and instances
   // ---------------------------------------------
   localparam logic [4:0] ACT [3] = '{5'h14, 5'h1f, 5'h0b};
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic lrst_i = 1'b0;
   logic cyc_i = 1'b0;
   logic stb_i = 1'b0;
   logic we_i = 1'b0;
   logic [ADR_W-1:0] adr_i = '0;
   logic [3:0] sel_i = 4'h0;
   logic [31:0] dat_i = 32'h0;
   logic clr = 1'b0;
   logic slow = 1'b0;
   logic [31:0] dat_o;
   logic [31:0] q;
   logic ack_o, op_valid_o, op_ready_i, op_global_o, req_stall_o, freeze_o, valid_at_ack;
   logic op_l2_wb_o, op_l2_inv_o, op_l1d_wb_o, op_l1d_inv_o, op_l1p_inv_o;
   logic alloc_en_o, lru_upd_en_o, miss_bypass_o;
   logic [LINE_W-1:0] op_line_o, first_line, last_line;
   logic [2:0] size_eff_o;
   logic [SET_W-1:0] last_set_o;
   logic [15:0] hs_count;
   logic [4:0] flags_seen;
   int miscompares = 0;
   int samples_checked = 0;
   wire logic [4:0] flags = {op_l2_wb_o, op_l2_inv_o, op_l1d_wb_o, op_l1d_inv_o, op_l1p_inv_o};

   always #50 clk_i = ~clk_i;

   l2_mode_coherence_ctrl l2_mode_coherence_ctrl_i (
      .clk_i(clk_i), .rst_i(rst_i), .lrst_i(lrst_i), .ce_i(1'b1), .cyc_i(cyc_i),
      .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
      .dat_o(dat_o), .ack_o(ack_o), .op_valid_o(op_valid_o), .op_ready_i(op_ready_i),
      .op_global_o(op_global_o), .op_line_o(op_line_o), .op_l2_wb_o(op_l2_wb_o),
      .op_l2_inv_o(op_l2_inv_o), .op_l1d_wb_o(op_l1d_wb_o), .op_l1d_inv_o(op_l1d_inv_o),
      .op_l1p_inv_o(op_l1p_inv_o), .req_stall_o(req_stall_o), .size_eff_o(size_eff_o),
      .last_set_o(last_set_o), .freeze_o(freeze_o), .alloc_en_o(alloc_en_o),
      .lru_upd_en_o(lru_upd_en_o), .miss_bypass_o(miss_bypass_o));

   l2_op_sink l2_op_sink_i (
      .clk_i(clk_i), .clr_i(clr | rst_i | lrst_i), .slow_i(slow), .op_valid_i(op_valid_o),
      .op_line_i(op_line_o), .flags_i(flags), .op_ready_o(op_ready_i),
      .hs_count_o(hs_count), .first_line_o(first_line), .last_line_o(last_line),
      .flags_seen_o(flags_seen));

   // ---------------------------------------------
   // Shared tasks
   // ---------------------------------------------
   task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic wb(input logic w, input logic [ADR_W-1:0] a, input logic [31:0] d,
                     output logic [31:0] r);
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      sel_i <= 4'hf;
      dat_i <= d;
      @(posedge clk_i);
      while (ack_o !== 1'b1) @(posedge clk_i);
      r = dat_o;
      valid_at_ack = op_valid_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      we_i <= 1'b0;
   endtask

   task automatic wr(input logic [ADR_W-1:0] a, input logic [31:0] d);
      logic [31:0] unused;
      wb(1'b1, a, d, unused);
   endtask

   task automatic rd(input logic [ADR_W-1:0] a, output logic [31:0] d);
      wb(1'b0, a, 32'h0, d);
   endtask

   task automatic clear_sink();
      @(posedge clk_i);
      clr <= 1'b1;
      @(posedge clk_i);
      clr <= 1'b0;
   endtask

   task automatic wait_idle();
      @(posedge clk_i);
      for (int n = 0; n < 20000 && op_valid_o !== 1'b0; n++) @(posedge clk_i);
   endtask

   // ---------------------------------------------
   // Scenarios
   // ---------------------------------------------
   task automatic t_reset();
      check("stall in reset", {31'h0, req_stall_o}, 32'h1);
      check("reset actions", {27'h0, flags}, 32'h0b);
      check("reset walk global", {31'h0, op_global_o}, 32'h1);
      rst_i <= 1'b0;
      rd(CFG_OFF, q);
      check("reset size", q & 32'h7, 32'h0);
      check("reset walk lines", {16'h0, hs_count}, 32'h200);
      check("stall released", {31'h0, req_stall_o}, 32'h0);
   endtask

   task automatic t_sizes();
      logic [2:0] codes [9] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h7, 3'h6, 3'h0, 3'h1};
      logic [2:0] eff;
      logic [2:0] old_eff;
      logic [2:0] prev;
      int sets;
      old_eff = 3'h0;
      prev = 3'h0;
      for (int i = 0; i < 9; i++) begin
         eff = (codes[i] > 3'h4) ? 3'h4 : codes[i];
         clear_sink();
         wr(CFG_OFF, {29'h0, codes[i]});
         rd(CFG_OFF, q);
         check("busy at config ack", {31'h0, valid_at_ack}, 32'h0);
         check("config size", q & 32'h7, {29'h0, codes[i]});
         rd(STAT_OFF, q);
         check("status size", {29'h0, q[6:4]}, {29'h0, eff});
         check("size out", {29'h0, size_eff_o}, {29'h0, eff});
         if (eff != 3'h0) check("last set", 32'(last_set_o), (32'h40 << (eff - 1)) - 1);
         sets = (old_eff != 3'h0 && codes[i] != prev) ? (64 << (old_eff - 1)) : 0;
         check("flush lines", {16'h0, hs_count}, 32'(sets));
         if (sets != 0) check("flush actions", {27'h0, flags_seen}, 32'h18);
         old_eff = eff;
         prev = codes[i];
      end
   endtask

   task automatic t_freeze_global();
      wr(CFG_OFF, 32'h9);
      @(posedge clk_i);
      check("freeze", {31'h0, freeze_o}, 32'h1);
      check("allocation frozen", {31'h0, alloc_en_o}, 32'h0);
      check("replacement order", {31'h0, lru_upd_en_o}, 32'h0);
      check("miss bypass", {31'h0, miss_bypass_o}, 32'h1);
      for (int i = 0; i < 3; i++) begin
         slow <= (i == 1);
         clear_sink();
         wr(GCMD_OFF + 8'(4 * i), 32'h1);
         rd(GCMD_OFF + 8'(4 * i), q);
         check("command pending", q & 32'h1, 32'h1);
         if (i == 1) begin
            wr(BLK_OFF, 32'h0);
            check("busy at base ack", {31'h0, valid_at_ack}, 32'h0);
         end
         wait_idle();
         check("global lines", {16'h0, hs_count}, 32'h40);
         check("global last line", 32'(last_line), 32'h3f);
         check("global actions", {27'h0, flags_seen}, {27'h0, ACT[i]});
         rd(GCMD_OFF + 8'(4 * i), q);
         check("command done", q & 32'h1, 32'h0);
         check("freeze kept", {31'h0, freeze_o}, 32'h1);
      end
      wr(CFG_OFF, 32'h1);
      @(posedge clk_i);
      check("allocation back", {31'h0, alloc_en_o}, 32'h1);
      check("bypass off", {31'h0, miss_bypass_o}, 32'h0);
   endtask

   task automatic t_block();
      logic [31:0] base;
      logic [31:0] last_byte;
      base = 32'h8000_007c;
      last_byte = base + 32'h0000_0fff;
      slow <= 1'b1;
      for (int i = 0; i < 3; i++) begin
         clear_sink();
         wr(BLK_OFF + 8'(8 * i), base);
         wr(BLK_OFF + 8'(8 * i + 4), 32'h400);
         check("block addressing", {31'h0, op_global_o}, 32'h0);
         rd(BLK_OFF + 8'(8 * i + 4), q);
         check("count while busy", q, 32'h400);
         wait_idle();
         check("block lines", {16'h0, hs_count}, 32'h21);
         check("block first line", 32'(first_line), {7'h0, base[31:7]});
         check("block last line", 32'(last_line), {7'h0, last_byte[31:7]});
         check("block actions", {27'h0, flags_seen}, {27'h0, ACT[i]});
         rd(BLK_OFF + 8'(8 * i + 4), q);
         check("count done", q, 32'h0);
      end
      clear_sink();
      wr(BLK_OFF + 8'h4, 32'h0);
      repeat (4) @(posedge clk_i);
      check("zero count lines", {16'h0, hs_count}, 32'h0);
   endtask

   task automatic t_local();
      wr(GCMD_OFF + 8'h8, 32'h1);
      repeat (3) @(posedge clk_i);
      lrst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      check("stall in local reset", {31'h0, req_stall_o}, 32'h1);
      lrst_i <= 1'b0;
      slow <= 1'b0;
      wait_idle();
      check("local walk lines", {16'h0, hs_count}, 32'h200);
      check("local actions", {27'h0, flags_seen}, 32'h0b);
      rd(CFG_OFF, q);
      check("size kept", q & 32'h7, 32'h1);
      check("stall after local", {31'h0, req_stall_o}, 32'h0);
   endtask

   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   initial begin
      repeat (6) @(posedge clk_i);
      t_reset();
      t_sizes();
      t_freeze_global();
      t_block();
      t_local();
      report_and_stop();
   end

   initial begin
      repeat (60000) @(posedge clk_i);
      miscompares++;
      report_and_stop();
   end
endmodule
